// ### fcph_top.sv
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module fcph_top
  import fcph_pkg::*;
#(
  parameter int TICK_CYCLES = FCPH_CYC_PER_MS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Sequencer handshakes from the data path
  input wire logic seek_done_i,
  input wire logic sector_done_i,
  // Drive and format outputs
  output logic seek_req_o,
  output logic head_load_o,
  output logic head_select_o,
  output logic [7:0] sector_o,
  output logic xfer_active_o,
  output logic write_o,
  output logic cmd_done_o,
  output logic mfm_o,
  output logic [7:0] gap2_len_o,
  output logic [7:0] intersector_gap_length_o,
  // Configure settings and reset
  output logic fifo_enable_n_o,
  output logic [3:0] fifo_threshold_o,
  output logic [7:0] precomp_start_track_o,
  output logic sw_reset_o
);
  // Registers
  logic [31:0] ctrl;
  logic [31:0] param;
  logic [31:0] timing;
  logic [31:0] config_reg;
  logic [31:0] rate_reg;
  logic [31:0] doc_reg;
  // Sequencer state
  fcph_state_type state;
  logic unload_pending;
  logic cur_head;
  logic [7:0] cur_sector;
  // Bus decode
  logic wr_stb;
  logic wr_ctrl;
  logic wr_param;
  logic wr_tim;
  logic wr_cfg;
  logic wr_rate;
  logic wr_doc;
  logic [31:0] wmask;
  logic [31:0] next_rate;
  logic [31:0] next_doc;
  logic go;
  logic soft_rst;
  logic tick;
  // Parameter fields
  logic [7:0] first_sector;
  logic [7:0] final_sector_number;
  logic [6:0] head_load_delay;
  logic [3:0] head_unload_delay;
  logic multi_track_flag;
  logic implied_seek_enable;
  logic go_seek_enable;
  logic lock;

  // One timer serves both head delays, which never run at once
  fcph_dly_if #(.W(FCPH_DLY_W)) dly ();

  // Field views of the registers
  assign first_sector = param[FCPH_PRM_SEC +: 8];
  assign final_sector_number = param[FCPH_PRM_EOT +: 8];
  assign head_load_delay = timing[FCPH_TIM_HLT +: 7];
  assign head_unload_delay = timing[FCPH_TIM_HUT +: 4];
  assign multi_track_flag = ctrl[FCPH_CTRL_MT];
  assign implied_seek_enable = ctrl[FCPH_CTRL_EIS];
  assign lock = ctrl[FCPH_CTRL_LOCK];

  // Byte lane mask from the select lines
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{sel_i[i]}};
    end
  end

  // A write is taken once, at the edge where the master samples ack
  assign wr_stb = cyc_i && stb_i && we_i && ack_o;
  assign wr_ctrl = wr_stb && (adr_i == FCPH_OFS_CTRL);
  assign wr_param = wr_stb && (adr_i == FCPH_OFS_PARAM);
  assign wr_tim = wr_stb && (adr_i == FCPH_OFS_TIMING);
  assign wr_cfg = wr_stb && (adr_i == FCPH_OFS_CONFIG);
  assign wr_rate = wr_stb && (adr_i == FCPH_OFS_RATE);
  assign wr_doc = wr_stb && (adr_i == FCPH_OFS_DOC);
  assign next_rate = (rate_reg & ~wmask) | (dat_i & wmask);
  assign next_doc = (doc_reg & ~wmask) | (dat_i & wmask);

  // Command start is a write-one strobe, ignored while busy
  assign go = wr_ctrl && sel_i[1] && dat_i[FCPH_CTRL_GO];

  // A GO that also writes the seek enable uses the value it writes
  assign go_seek_enable = sel_i[0] ? dat_i[FCPH_CTRL_EIS] : implied_seek_enable;

  // Wishbone ack: one cycle per access, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Read data, registered with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_o) begin
      case (adr_i)
        FCPH_OFS_CTRL: dat_o <= ctrl;
        FCPH_OFS_PARAM: dat_o <= param;
        FCPH_OFS_TIMING: dat_o <= timing;
        FCPH_OFS_CONFIG: dat_o <= config_reg;
        FCPH_OFS_RATE: dat_o <= rate_reg;
        FCPH_OFS_DOC: dat_o <= doc_reg;
        FCPH_OFS_STATUS: dat_o <= {16'h0000, cur_sector, 1'b0, 3'(state),
                                   unload_pending, cur_head, head_load_o,
                                   (state != FCPH_IDLE)};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Software reset: set rate bit or cleared drive-control bit, one pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= (wr_rate && next_rate[FCPH_RATE_RST]) ||
                  (wr_doc && !next_doc[FCPH_DOC_RSTN]);
    end
  end
  assign sw_reset_o = soft_rst;

  // Rate register; its reset bit clears itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_reg <= FCPH_RATE_RSTV;
    end else if (wr_rate) begin
      rate_reg <= next_rate & ~(32'h0000_0001 << FCPH_RATE_RST);
    end
  end

  // Drive output control register, stores what software wrote
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      doc_reg <= FCPH_DOC_RSTV;
    end else if (wr_doc) begin
      doc_reg <= next_doc;
    end
  end

  // Control register; lock survives a software reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= FCPH_CTRL_RST;
    end else if (soft_rst) begin
      ctrl <= (FCPH_CTRL_RST & ~(32'h0000_0001 << FCPH_CTRL_LOCK)) |
              (ctrl & (32'h0000_0001 << FCPH_CTRL_LOCK));
    end else if (wr_ctrl) begin
      ctrl <= ((ctrl & ~wmask) | (dat_i & wmask)) & FCPH_CTRL_MASK &
              ~(32'h0000_0001 << FCPH_CTRL_GO);
    end
  end

  // Command parameters: sector, final sector, gap 3, gap 2
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      param <= FCPH_PARAM_RST;
    end else if (wr_param) begin
      param <= (param & ~wmask) | (dat_i & wmask);
    end
  end

  // Head load and unload delays
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      timing <= FCPH_TIM_RST;
    end else if (wr_tim) begin
      timing <= ((timing & ~wmask) | (dat_i & wmask)) & FCPH_TIM_MASK;
    end
  end

  // Configure settings return to defaults on a software reset only when not locked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_reg <= FCPH_CFG_RST;
    end else if (soft_rst && !lock) begin
      config_reg <= FCPH_CFG_RST;
    end else if (wr_cfg) begin
      config_reg <= ((config_reg & ~wmask) | (dat_i & wmask)) & FCPH_CFG_MASK;
    end
  end

  // Format outputs straight from register flops
  assign mfm_o = ctrl[FCPH_CTRL_MFM];
  assign intersector_gap_length_o = param[FCPH_PRM_GPL +: 8];
  assign fifo_enable_n_o = config_reg[FCPH_CFG_FIFO_ENABLE_N];
  assign fifo_threshold_o = config_reg[FCPH_CFG_THR +: 4];
  assign precomp_start_track_o = config_reg[FCPH_CFG_PRE +: 8];

  // Gap 2 follows the parameter only for perpendicular drives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap2_len_o <= FCPH_GAP2_STD;
    end else begin
      gap2_len_o <= ctrl[FCPH_CTRL_PERP] ? param[FCPH_PRM_GAP2 +: 8]
                                         : FCPH_GAP2_STD;
    end
  end

  // Millisecond enable for the head timers
  fcph_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // Shared head timer; a soft reset abandons any wait
  fcph_delay u_delay (
    .clk_i(clk_i),
    .rst_i(rst_i || soft_rst),
    .tick_i(tick),
    .dly(dly.timer)
  );

  // Command sequencer: seek, head load, sector walk
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      state <= FCPH_IDLE;
      cur_head <= 1'b0;
      cur_sector <= 8'h00;
      write_o <= 1'b0;
      seek_req_o <= 1'b0;
      cmd_done_o <= 1'b0;
    end else begin
      seek_req_o <= 1'b0;
      cmd_done_o <= 1'b0;
      case (state)
        FCPH_IDLE: begin
          if (go) begin
            cur_head <= dat_i[FCPH_CTRL_HEAD];
            cur_sector <= first_sector;
            write_o <= dat_i[FCPH_CTRL_WR];
            if (go_seek_enable && dat_i[FCPH_CTRL_CYL]) begin
              seek_req_o <= 1'b1;
              state <= FCPH_SEEK;
            end else begin
              state <= FCPH_PREP;
            end
          end
        end
        FCPH_SEEK: begin
          if (seek_done_i) begin
            state <= FCPH_PREP;
          end
        end
        FCPH_PREP: begin
          // An already loaded head needs no second settle time
          state <= head_load_o ? FCPH_XFER : FCPH_HLOAD;
        end
        FCPH_HLOAD: begin
          if (dly.expired) begin
            state <= FCPH_XFER;
          end
        end
        FCPH_XFER: begin
          if (sector_done_i) begin
            if (cur_sector != final_sector_number) begin
              cur_sector <= cur_sector + 1'b1;
            end else if (multi_track_flag && !cur_head) begin
              cur_head <= 1'b1;
              cur_sector <= FCPH_FIRST_SECTOR;
            end else begin
              state <= FCPH_IDLE;
              cmd_done_o <= 1'b1;
            end
          end
        end
        default: state <= FCPH_IDLE;
      endcase
    end
  end

  // Head load line and pending unload
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      head_load_o <= 1'b0;
      unload_pending <= 1'b0;
    end else if (state == FCPH_PREP && !head_load_o) begin
      head_load_o <= 1'b1;
    end else if (state == FCPH_XFER && sector_done_i &&
                 cur_sector == final_sector_number &&
                 !(multi_track_flag && !cur_head)) begin
      unload_pending <= 1'b1;
    end else if (go && state == FCPH_IDLE) begin
      unload_pending <= 1'b0; // New command keeps the head loaded
    end else if (unload_pending && dly.expired) begin
      head_load_o <= 1'b0;
      unload_pending <= 1'b0;
    end
  end

  // Timer starts: load delay on head load, unload delay at end
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      dly.start <= 1'b0;
      dly.count <= '0;
    end else begin
      dly.start <= 1'b0;
      if (state == FCPH_PREP && !head_load_o) begin
        dly.start <= 1'b1;
        dly.count <= FCPH_DLY_W'(head_load_delay * FCPH_HLT_UNIT_MS);
      end else if (state == FCPH_XFER && sector_done_i &&
                   cur_sector == final_sector_number &&
                   !(multi_track_flag && !cur_head)) begin
        dly.start <= 1'b1;
        dly.count <= FCPH_DLY_W'(head_unload_delay * FCPH_HUT_UNIT_MS);
      end
    end
  end

  // Transfer outputs
  assign head_select_o = cur_head;
  assign sector_o = cur_sector;
  assign xfer_active_o = (state == FCPH_XFER);
endmodule

// ### fcph_pkg.sv
package fcph_pkg;
  // Timebase: one millisecond expressed in clock cycles
  localparam int FCPH_CLK_PERIOD_NS = 100;
  localparam int FCPH_MS_NS = 1_000_000;
  localparam int FCPH_CYC_PER_MS = FCPH_MS_NS / FCPH_CLK_PERIOD_NS;
  // Delay units of the head load and unload fields, in ms
  localparam int FCPH_HLT_UNIT_MS = 2;
  localparam int FCPH_HUT_UNIT_MS = 16;
  localparam int FCPH_DLY_W = 12;
  // Register byte offsets
  localparam logic [7:0] FCPH_OFS_CTRL = 8'h00;
  localparam logic [7:0] FCPH_OFS_PARAM = 8'h04;
  localparam logic [7:0] FCPH_OFS_TIMING = 8'h08;
  localparam logic [7:0] FCPH_OFS_CONFIG = 8'h0C;
  localparam logic [7:0] FCPH_OFS_RATE = 8'h10;
  localparam logic [7:0] FCPH_OFS_DOC = 8'h14;
  localparam logic [7:0] FCPH_OFS_STATUS = 8'h18;
  // Control register bits
  localparam int FCPH_CTRL_EIS = 0;
  localparam int FCPH_CTRL_MFM = 1;
  localparam int FCPH_CTRL_MT = 2;
  localparam int FCPH_CTRL_HEAD = 3;
  localparam int FCPH_CTRL_PERP = 4;
  localparam int FCPH_CTRL_LOCK = 5;
  localparam int FCPH_CTRL_GO = 8;
  localparam int FCPH_CTRL_WR = 9;
  localparam int FCPH_CTRL_CYL = 10;
  localparam logic [31:0] FCPH_CTRL_MASK = 32'h0000_063F;
  // Parameter register fields (8 bits each)
  localparam int FCPH_PRM_SEC = 0;
  localparam int FCPH_PRM_EOT = 8;
  localparam int FCPH_PRM_GPL = 16;
  localparam int FCPH_PRM_GAP2 = 24;
  // Timing register fields
  localparam int FCPH_TIM_HLT = 0;
  localparam int FCPH_TIM_HUT = 8;
  localparam logic [31:0] FCPH_TIM_MASK = 32'h0000_0F7F;
  // Configure register fields
  localparam int FCPH_CFG_FIFO_ENABLE_N = 0;
  localparam int FCPH_CFG_THR = 4;
  localparam int FCPH_CFG_PRE = 8;
  localparam logic [31:0] FCPH_CFG_MASK = 32'h0000_FFF1;
  // Reset bits of the rate select and drive output control registers
  localparam int FCPH_RATE_RST = 7;
  localparam int FCPH_DOC_RSTN = 2;
  // Reset values
  localparam logic [31:0] FCPH_CTRL_RST = 32'h0000_0002;
  localparam logic [31:0] FCPH_PARAM_RST = 32'h0000_0000;
  localparam logic [31:0] FCPH_TIM_RST = 32'h0000_0000;
  localparam logic [31:0] FCPH_CFG_RST = 32'h0000_0001;
  localparam logic [31:0] FCPH_RATE_RSTV = 32'h0000_0000;
  localparam logic [31:0] FCPH_DOC_RSTV = 32'h0000_0004;
  // Sector and gap constants
  localparam logic [7:0] FCPH_FIRST_SECTOR = 8'h01;
  localparam logic [7:0] FCPH_GAP2_STD = 8'h16;
  // Sequencer states
  typedef enum logic [2:0] {
    FCPH_IDLE,
    FCPH_SEEK,
    FCPH_PREP,
    FCPH_HLOAD,
    FCPH_XFER
  } fcph_state_type;
endpackage

// ### fcph_dly_if.sv
`timescale 1ns/1ps
interface fcph_dly_if #(parameter int W = 12);
  logic start;
  logic [W-1:0] count;
  logic busy;
  logic expired;
  modport ctrl (output start, output count, input busy, input expired);
  modport timer (input start, input count, output busy, output expired);
endinterface

// ### fcph_tick.sv
`timescale 1ns/1ps
module fcph_tick #(
  parameter int CYCLES = 10000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Millisecond enable
  output logic tick_o
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt;

  // Free running divider, one-cycle enable per wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (cnt == W'(CYCLES - 1)) begin
      cnt <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule

// ### fcph_delay.sv
`timescale 1ns/1ps
module fcph_delay (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Timebase enable
  input wire logic tick_i,
  // Control side
  fcph_dly_if.timer dly
);
  logic [$bits(dly.count)-1:0] cnt;

  // Down counter in ticks; expiry on the tick after the count runs out, so no wait is short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      dly.busy <= 1'b0;
      dly.expired <= 1'b0;
    end else begin
      dly.expired <= 1'b0;
      if (dly.start) begin
        cnt <= dly.count;
        dly.busy <= 1'b1;
      end else if (dly.busy && tick_i) begin
        // Tick phase is free running, so the first tick may come at once
        if (cnt == '0) begin
          dly.busy <= 1'b0;
          dly.expired <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end
endmodule

// ### fcph_top_assertions.sv
`timescale 1ns/1ps
module fcph_top_assertions
  import fcph_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  // Sequencer and settings
  input wire logic sector_done_i, seek_req_o, head_select_o, xfer_active_o, head_load_o,
  input wire logic cmd_done_o, mfm_o, sw_reset_o, fifo_enable_n_o,
  input wire logic [7:0] sector_o, gap2_len_o, intersector_gap_length_o, precomp_start_track_o,
  input wire logic [3:0] fifo_threshold_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr, go, last, turn, sw_wr, busy;
  logic [7:0] ctl, fin;
  logic [12:0] cfg;
  // Bus decode; only the byte lanes that carry each field count
  assign wr = cyc_i && stb_i && we_i && ack_o;
  assign go = wr && adr_i == FCPH_OFS_CTRL && sel_i[1:0] == 2'b11 && dat_i[FCPH_CTRL_GO] && !busy;
  assign last = sector_done_i && xfer_active_o && sector_o == fin;
  assign turn = ctl[FCPH_CTRL_MT] && !head_select_o;
  assign sw_wr = wr && sel_i[0] && ((adr_i == FCPH_OFS_RATE && dat_i[FCPH_RATE_RST])
    || (adr_i == FCPH_OFS_DOC && !dat_i[FCPH_DOC_RSTN]));
  assign cfg = {fifo_enable_n_o, fifo_threshold_o, precomp_start_track_o};
  // Shadow of control byte and final sector; soft reset spares the lock bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= 8'h02;
      fin <= 8'h00;
    end else if (sw_reset_o) begin
      ctl <= 8'h02 | (ctl & 8'h20);
      fin <= 8'h00;
    end else begin
      if (wr && adr_i == FCPH_OFS_CTRL && sel_i[0]) ctl <= dat_i[7:0];
      if (wr && adr_i == FCPH_OFS_PARAM && sel_i[1]) fin <= dat_i[15:8];
    end
  end
  // Command in flight, so a GO while busy is not mistaken for a start
  always_ff @(posedge clk_i) begin
    if (rst_i || sw_reset_o || cmd_done_o) busy <= 1'b0;
    else if (go) busy <= 1'b1;
  end
  AST_SEEK_ON_GO: assert property (go && dat_i[FCPH_CTRL_EIS] && dat_i[FCPH_CTRL_CYL] |=> seek_req_o)
    else $error("no seek after go with implied seek");
  AST_SEEK_ONLY_ENABLED: assert property (seek_req_o |-> $past(go && dat_i[FCPH_CTRL_EIS]))
    else $error("seek without implied seek enable");
  AST_GAP3: assert property (wr && adr_i == FCPH_OFS_PARAM && sel_i[2]
    |=> intersector_gap_length_o == $past(dat_i[23:16])) else $error("gap 3 length wrong");
  AST_GAP2_STD: assert property (xfer_active_o && !ctl[FCPH_CTRL_PERP]
    |-> gap2_len_o == FCPH_GAP2_STD) else $error("gap 2 not standard");
  AST_DENSITY: assert property (wr && adr_i == FCPH_OFS_CTRL && sel_i[0]
    |=> mfm_o == $past(dat_i[FCPH_CTRL_MFM])) else $error("density select wrong");
  AST_STEP: assert property (sector_done_i && xfer_active_o && sector_o != fin
    |=> sector_o == $past(sector_o) + 8'h01 && !cmd_done_o) else $error("sector step wrong");
  AST_END: assert property (last && !turn |-> ##[1:2] cmd_done_o)
    else $error("no end at final sector");
  AST_TURN: assert property (last && turn |=> head_select_o && sector_o == FCPH_FIRST_SECTOR
    && xfer_active_o && !cmd_done_o) else $error("no head 1 continuation");
  AST_LOADED: assert property ($rose(xfer_active_o) |-> head_load_o && $past(head_load_o))
    else $error("transfer without loaded head");
  AST_SWRST: assert property (sw_wr |-> ##1 sw_reset_o)
    else $error("no software reset pulse");
  AST_KEEP: assert property (sw_reset_o && ctl[FCPH_CTRL_LOCK] |=> cfg == $past(cfg, 2))
    else $error("locked settings lost");
  AST_DEFAULT: assert property (sw_reset_o && !ctl[FCPH_CTRL_LOCK] |=> cfg == 13'h1000)
    else $error("unlocked settings kept");
  COV_GO: cover property (go);
  COV_TURN: cover property (last && turn);
  COV_LOCKED: cover property (sw_reset_o && ctl[FCPH_CTRL_LOCK]);
endmodule

// ### fcph_drive_model.sv
`timescale 1ns/1ps
module fcph_drive_model (
  // Clock, reset and pace
  input wire logic clk_i, rst_i,
  input wire logic [3:0] lat_i,
  // Block side
  input wire logic seek_req_o, xfer_active_o,
  output logic seek_done_i, sector_done_i
);
  logic [3:0] cnt;
  logic seeking;
  // Seek then sector pulses, at least lat_i idle cycles apart; never two pulses back to back
  always_ff @(posedge clk_i) begin
    seek_done_i <= 1'b0;
    sector_done_i <= 1'b0;
    if (rst_i) begin
      cnt <= 4'h0;
      seeking <= 1'b0;
    end else if (seek_req_o) begin
      seeking <= 1'b1;
      cnt <= lat_i;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (seeking) begin
      seeking <= 1'b0;
      seek_done_i <= 1'b1;
    end else if (xfer_active_o && !sector_done_i) begin
      sector_done_i <= 1'b1;
      cnt <= lat_i;
    end
  end
endmodule

// ### floppy_command_param_handling_test.sv
`timescale 1ns/1ps
module floppy_command_param_handling_test;
  import fcph_pkg::*;
  localparam int TK = 4;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF, lat_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o, seek_done_i, sector_done_i, seek_req_o, head_load_o, head_select_o, write_o;
  logic xfer_active_o, cmd_done_o, mfm_o, fifo_enable_n_o, sw_reset_o, sk;
  logic hl_d = 1'b0, xa_d = 1'b0;
  logic [7:0] sector_o, gap2_len_o, intersector_gap_length_o, precomp_start_track_o;
  logic [3:0] fifo_threshold_o;
  logic [8:0] seen[$];
  int mismatches = 0, total_checks = 0, cyc_n = 0, t_hl, t_ul, t_xa, t_cd;
  fcph_top #(.TICK_CYCLES(TK)) fcph_top_i (.*);
  fcph_drive_model fcph_drive_model_i (.*);
  always #50 clk_i = ~clk_i;
  // Edge times, sector log and the hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (head_load_o && !hl_d) t_hl = cyc_n;
    if (!head_load_o && hl_d) t_ul = cyc_n;
    if (xfer_active_o && !xa_d) t_xa = cyc_n;
    if (cmd_done_o) t_cd = cyc_n;
    if (seek_req_o) sk = 1'b1;
    if (sector_done_i && xfer_active_o) seen.push_back({head_select_o, sector_o});
    hl_d = head_load_o;
    xa_d = xfer_active_o;
    if (cyc_n > 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rng(input int v, input int lo, input int hi);
    total_checks++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("BAD %0t got %h exp %h..%h", $time, v, lo, hi);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled, then drop for a cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task t_regs;
    wb(1'b0, FCPH_OFS_CTRL, 32'h0);
    chk(rd, FCPH_CTRL_RST);
    wb(1'b0, FCPH_OFS_CONFIG, 32'h0);
    chk(rd, FCPH_CFG_RST);
    wb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    chk(gap2_len_o, FCPH_GAP2_STD);
    wb(1'b1, FCPH_OFS_PARAM, 32'h5A3B0201);
    wb(1'b1, FCPH_OFS_CTRL, 32'h10);
    repeat (2) @(posedge clk_i);
    chk(intersector_gap_length_o, 32'h3B);
    chk(gap2_len_o, 32'h5A);
    chk(mfm_o, 1'b0);
    wb(1'b1, FCPH_OFS_CTRL, 32'h2);
    repeat (2) @(posedge clk_i);
    chk(mfm_o, 1'b1);
    chk(gap2_len_o, FCPH_GAP2_STD);
    $display("register test end");
  endtask
  // Expected head and sector order worked out from control and parameter words
  task run_cmd(input logic [31:0] ctl, input logic [31:0] prm);
    logic [8:0] q[$];
    int n;
    seen.delete();
    q.delete();
    sk = 1'b0;
    for (int s = prm[7:0]; s <= prm[15:8]; s++) q.push_back({ctl[FCPH_CTRL_HEAD], s[7:0]});
    if (ctl[FCPH_CTRL_MT] && !ctl[FCPH_CTRL_HEAD])
      for (int s = 1; s <= prm[15:8]; s++) q.push_back({1'b1, s[7:0]});
    wb(1'b1, FCPH_OFS_PARAM, prm);
    wb(1'b1, FCPH_OFS_CTRL, ctl | 32'h100);
    while (cmd_done_o !== 1'b1) @(posedge clk_i);
    chk(sk, ctl[FCPH_CTRL_EIS] & ctl[FCPH_CTRL_CYL]);
    chk(write_o, ctl[FCPH_CTRL_WR]);
    chk(seen.size(), q.size());
    n = seen.size() < q.size() ? seen.size() : q.size();
    for (int i = 0; i < n; i++) chk(seen[i], q[i]);
    $display("command %h end", ctl);
  endtask
  task t_timing;
    wb(1'b1, FCPH_OFS_TIMING, 32'h101);
    while (head_load_o !== 1'b0) @(posedge clk_i);
    run_cmd(32'h2, 32'h0101);
    rng(t_xa - t_hl, 2 * TK, 3 * TK + 2);
    while (head_load_o !== 1'b0) @(posedge clk_i);
    @(posedge clk_i);
    rng(t_ul - t_cd, 16 * TK, 17 * TK + 2);
    $display("head timing test end");
  endtask
  task t_swrst;
    wb(1'b1, FCPH_OFS_CONFIG, 32'h1230);
    wb(1'b1, FCPH_OFS_CTRL, 32'h22);
    wb(1'b1, FCPH_OFS_RATE, 32'h80);
    repeat (3) @(posedge clk_i);
    chk({fifo_enable_n_o, fifo_threshold_o, precomp_start_track_o}, 13'h0312);
    wb(1'b0, FCPH_OFS_CTRL, 32'h0);
    chk(rd, FCPH_CTRL_RST | 32'h20);
    wb(1'b1, FCPH_OFS_CTRL, 32'h2);
    wb(1'b1, FCPH_OFS_DOC, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({fifo_enable_n_o, fifo_threshold_o, precomp_start_track_o}, 13'h1000);
    wb(1'b1, FCPH_OFS_DOC, 32'h4);
    $display("software reset test end");
  endtask
  // Seek on and off, multi-track from head 0, single sector on head 1, FM
  localparam logic [31:0] CT[4] = '{32'h0403, 32'h0006, 32'h060A, 32'h0001};
  localparam logic [31:0] PR[4] = '{32'h0503, 32'h0504, 32'h0202, 32'h0101};
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    for (int i = 0; i < 4; i++) begin
      lat_i <= 4'(i * 3);
      run_cmd(CT[i], PR[i]);
    end
    t_timing();
    t_swrst();
    complete_run();
  end
endmodule
bind fcph_top fcph_top_assertions fcph_top_assertions_i (.*);
